// >>> hw/hf_clock_divider.v
// Purpose: high-frequency clock output by phase accumulation
// Assumes: step input already includes the plus-one term
// Notes:   sync_clear restarts the phase; caller gates it off
//          while high-frequency mode runs
`timescale 1ns/1ns
`include "mirror_consts.vh"

module hf_clock_divider (
  input  wire                    hclk,       // system clock
  input  wire                    hresetn,    // async reset, low
  input  wire                    run,        // accumulate enable
  input  wire                    sync_clear, // restart phase
  input  wire [`HF_ACC_W-1:0]    step,       // divider code + 1
  output wire                    clk_out     // divided clock
);

  reg [`HF_ACC_W-1:0] acc_q;

  // frequency rises linearly with step, one step per code
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= {`HF_ACC_W{1'b0}};
    end else if (sync_clear) begin
      acc_q <= {`HF_ACC_W{1'b0}};
    end else if (run) begin
      acc_q <= acc_q + step;
    end
  end

  assign clk_out = acc_q[`HF_ACC_W-1];

endmodule

// >>> hw/mirror_consts.vh
// Purpose: shared constants of the configuration mirror block
// Assumes: 100 MHz hclk, 32-bit AHB-Lite register port
// Notes:   register indices times four give byte addresses
`ifndef MIRROR_CONSTS_VH
`define MIRROR_CONSTS_VH

// register indices (byte address is four times the index)
`define IDX_TEMP_REF_OFFSET_LO      8'hc4
`define IDX_TEMP_REF_OFFSET_HI      8'hc5
`define IDX_PASS0        8'hc6
`define IDX_PASS1        8'hc7
`define IDX_PASS2        8'hc8
`define IDX_PASS3        8'hc9
`define IDX_CTRL         8'hd0
`define IDX_STATUS       8'hd1
`define IDX_CAL_TEMP     8'hd2
`define IDX_KEY          8'hd3
`define IDX_UNLOCK       8'hd4
`define IDX_NV_PASS      8'hd5

// control register fields
`define CTRL_HFD_MSB     12
`define CTRL_HFD_LSB     0
`define CTRL_HIGH_FREQ_OUTPUT_MODE     16
`define CTRL_EVENT_SYNC_SETTING        17

// status register fields
`define STAT_LOADED      0
`define STAT_PROTECT     1
`define STAT_UNLOCKED    2

// reset and key values
`define PASS_RESET       8'h00
`define BYTE_ZERO        8'h00
`define KEY_ENABLED      8'hff
`define HFD_RESET        13'h0000
`define WORD_ZERO        32'h0000_0000

// power-up refresh delay: 66 ms at a 10 ns clock
`define POWERUP_REFRESH_DELAY_MS        66
`define CLK_PERIOD_NS    10
`define NS_PER_MS        1000000
`define REFR_CNT_W       23

// hf divider accumulator width
`define HF_ACC_W         14

// ahb transfer type bit that marks NONSEQ or SEQ
`define HTRANS_ACTIVE    1

`endif

// >>> hw/temp_ref_and_passcode_mirror.v
// Purpose: mirror of temperature reference and passcode bytes,
//          with write protection and the clock output divider
// Assumes: nv_* inputs present the stored non-volatile values
// Notes:   AHB-Lite slave, reads take one wait state
// Functional notes
// - 13-bit code, output steps of 8.192 kHz; here steps of about 6.104 kHz (100 MHz hclk / 2^14 accumulator)
// - no compensation pulses in high-frequency mode
// - seconds write and event leave hf period
// - 16-bit two's complement reference calibrates temperature
// - one reference unit equals 0.0078125 degrees
// - reference low byte at first address
// - reference high byte at second address
// - reference loaded from storage after refresh delay
// - passcode loaded after same refresh delay
// - reference always readable, writes password protected
// - passcode bytes low to high address
// - passcode mirror write only, reads zero
// - stored passcode readable only when unlocked
// - passcode writes obey password protection
// - passcode bytes start at zero
// - protection enabled only when key is 255
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`include "mirror_consts.vh"

module temp_ref_and_passcode_mirror #(
  parameter [`REFR_CNT_W-1:0] REFRESH_CYCLES =
    (`POWERUP_REFRESH_DELAY_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
  input  wire        hclk,           // system clock
  input  wire        hresetn,        // async reset, low
  input  wire        hsel,           // slave select
  input  wire [31:0] haddr,          // byte address
  input  wire [1:0]  htrans,         // transfer type
  input  wire        hwrite,         // write when high
  input  wire [2:0]  hsize,          // transfer size
  input  wire        hready,         // bus ready in
  input  wire [31:0] hwdata,         // write data
  output wire [31:0] hrdata,         // read data
  output wire        hreadyout,      // slave ready
  output wire        hresp,          // always okay
  input  wire [15:0] nv_temp_ref,    // stored reference
  input  wire [31:0] nv_passcode,    // stored passcode
  input  wire [7:0]  nv_enable_key,  // stored enable key
  input  wire [15:0] raw_temp,       // measured temperature
  input  wire        seconds_write,  // seconds register written
  input  wire        external_event_input, // event detected
  input  wire        xtal_clk_in,    // low-frequency clock
  input  wire        comp_pulse,     // compensation pulse
  output wire [15:0] cal_temp,       // calibrated temperature
  output wire        clkout,         // clock output pin
  output wire        refresh_done    // mirrors loaded
);

  // register file
  reg [7:0]  temp_ref_offset_lo_q;
  reg [7:0]  temp_ref_offset_hi_q;
  reg [7:0]  pass_q [0:3];
  reg [7:0]  key_q;
  reg [31:0] entry_q;
  reg [12:0] hf_divider_code_q;
  reg        high_freq_output_mode_q;
  reg        event_sync_setting_q;

  // refresh timing
  reg [`REFR_CNT_W-1:0] refr_cnt_q;
  reg                   loaded_q;

  // bus state
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg [7:0]  idx_q;
  reg        idx_ok_q;
  reg [31:0] hrdata_q;

  wire       addr_take;
  wire       idx_ok;
  wire [7:0] idx;
  wire       wr_en;
  wire [31:0] passcode_mirror;
  wire [15:0] temp_ref_offset;
  wire       unlocked;
  wire       protect_on;
  wire       key_active;
  wire       hf_clk;
  wire       hf_sync_clear;
  reg [31:0] rd_mux;
  integer    i;

  assign passcode_mirror = {pass_q[3], pass_q[2],
                            pass_q[1], pass_q[0]};
  assign temp_ref_offset = {temp_ref_offset_hi_q, temp_ref_offset_lo_q};

  // password handling: key must equal 255 to enable protection
  assign key_active = (key_q == `KEY_ENABLED);
  assign unlocked   = (entry_q == passcode_mirror);
  assign protect_on = key_active && !unlocked;

  // power-up refresh counter; loads fire once when it expires
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refr_cnt_q <= {`REFR_CNT_W{1'b0}};
      loaded_q   <= 1'b0;
    end else if (!loaded_q) begin
      if (refr_cnt_q == REFRESH_CYCLES - 1'b1) begin
        loaded_q <= 1'b1;
      end else begin
        refr_cnt_q <= refr_cnt_q + 1'b1;
      end
    end
  end

  wire load_now;
  assign load_now = !loaded_q &&
                    (refr_cnt_q == REFRESH_CYCLES - 1'b1);
  assign refresh_done = loaded_q;

  // address decode: only word-aligned addresses map
  assign idx    = haddr[9:2];
  assign idx_ok = (haddr[1:0] == 2'b00) &&
                  (haddr[31:10] == 22'h000000);
  assign addr_take = hsel && hready &&
                     htrans[`HTRANS_ACTIVE];

  // capture the address phase; reads get one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= `BYTE_ZERO;
      idx_ok_q  <= 1'b0;
    end else begin
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
      end else if (hready) begin
        wr_pend_q <= addr_take && hwrite;
        rd_pend_q <= addr_take && !hwrite;
        if (addr_take) begin
          idx_q    <= idx;
          idx_ok_q <= idx_ok;
        end
      end
    end
  end

  assign hreadyout = !rd_pend_q;
  assign hresp     = 1'b0;
  assign wr_en     = wr_pend_q && idx_ok_q && hready;

  // read mux: write-only mirrors return zero
  always @* begin
    rd_mux = `WORD_ZERO;
    if (idx_ok_q) begin
      case (idx_q)
        `IDX_TEMP_REF_OFFSET_LO:  rd_mux[7:0] = temp_ref_offset_lo_q;
        `IDX_TEMP_REF_OFFSET_HI:  rd_mux[7:0] = temp_ref_offset_hi_q;
        `IDX_PASS0,
        `IDX_PASS1,
        `IDX_PASS2,
        `IDX_PASS3:    rd_mux = `WORD_ZERO;
        `IDX_CTRL: begin
          rd_mux[`CTRL_HFD_MSB:`CTRL_HFD_LSB] = hf_divider_code_q;
          rd_mux[`CTRL_HIGH_FREQ_OUTPUT_MODE] = high_freq_output_mode_q;
          rd_mux[`CTRL_EVENT_SYNC_SETTING]    = event_sync_setting_q;
        end
        `IDX_STATUS: begin
          rd_mux[`STAT_LOADED]   = loaded_q;
          rd_mux[`STAT_PROTECT]  = protect_on;
          rd_mux[`STAT_UNLOCKED] = unlocked;
        end
        `IDX_CAL_TEMP: rd_mux[15:0] = cal_temp;
        `IDX_NV_PASS: begin
          if (unlocked) begin
            rd_mux = nv_passcode;
          end
        end
        default:       rd_mux = `WORD_ZERO;
      endcase
    end
  end

  // read data flop, loaded in the wait cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `WORD_ZERO;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hrdata = hrdata_q;

  // temperature reference mirror: refresh load, then guarded writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_ref_offset_lo_q <= `BYTE_ZERO;
      temp_ref_offset_hi_q <= `BYTE_ZERO;
    end else if (load_now) begin
      temp_ref_offset_lo_q <= nv_temp_ref[7:0];
      temp_ref_offset_hi_q <= nv_temp_ref[15:8];
    end else if (wr_en && !protect_on) begin
      if (idx_q == `IDX_TEMP_REF_OFFSET_LO) begin
        temp_ref_offset_lo_q <= hwdata[7:0];
      end
      if (idx_q == `IDX_TEMP_REF_OFFSET_HI) begin
        temp_ref_offset_hi_q <= hwdata[7:0];
      end
    end
  end

  // passcode mirror bytes, lowest address holds bits 7:0
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        pass_q[i] <= `PASS_RESET;
      end
    end else if (load_now) begin
      for (i = 0; i < 4; i = i + 1) begin
        pass_q[i] <= nv_passcode[i*8 +: 8];
      end
    end else if (wr_en && !protect_on) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (idx_q == `IDX_PASS0 + i[7:0]) begin
          pass_q[i] <= hwdata[7:0];
        end
      end
    end
  end

  // enable key mirror; write only and protected
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_q <= `BYTE_ZERO;
    end else if (load_now) begin
      key_q <= nv_enable_key;
    end else if (wr_en && !protect_on &&
                 idx_q == `IDX_KEY) begin
      key_q <= hwdata[7:0];
    end
  end

  // entered password; always writable so the lock can open
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_q <= `WORD_ZERO;
    end else if (wr_en && idx_q == `IDX_UNLOCK) begin
      entry_q <= hwdata;
    end
  end

  // clock output control, protected like the other settings
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hf_divider_code_q    <= `HFD_RESET;
      high_freq_output_mode_q            <= 1'b0;
      event_sync_setting_q <= 1'b0;
    end else if (wr_en && !protect_on &&
                 idx_q == `IDX_CTRL) begin
      hf_divider_code_q    <=
        hwdata[`CTRL_HFD_MSB:`CTRL_HFD_LSB];
      high_freq_output_mode_q            <= hwdata[`CTRL_HIGH_FREQ_OUTPUT_MODE];
      event_sync_setting_q <= hwdata[`CTRL_EVENT_SYNC_SETTING];
    end
  end

  // calibrated temperature: each offset unit is 0.0078125 C
  assign cal_temp = raw_temp + temp_ref_offset;

  // resync only clears the hf divider phase, and only while high_freq_output_mode is off
  assign hf_sync_clear = !high_freq_output_mode_q &&
    (seconds_write ||
     (external_event_input && event_sync_setting_q));

  // divider steps with code + 1, giving equal frequency steps
  hf_clock_divider u_hf_div (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .run        (high_freq_output_mode_q),
    .sync_clear (hf_sync_clear),
    .step       ({1'b0, hf_divider_code_q} + 14'h0001),
    .clk_out    (hf_clk)
  );

  // compensation pulses act only on the low-frequency path
  assign clkout = high_freq_output_mode_q ? hf_clk :
                  (xtal_clk_in & !comp_pulse);

endmodule

// >>> sim/mirror_sva.sv
// Purpose: bus, load and offset checks for the mirror block
// Assumes: hready is tied to hreadyout
// Notes:   refresh_done is expected exactly REFRESH_CYCLES edges on
`timescale 1ns/1ns
`include "mirror_consts.vh"
module mirror_sva #(
  parameter [`REFR_CNT_W-1:0] REFRESH_CYCLES = 40
) (
  input wire        hclk,         // clock
  input wire        hresetn,      // reset, low
  input wire        hsel,         // select
  input wire [31:0] haddr,        // address
  input wire [1:0]  htrans,       // transfer type
  input wire        hwrite,       // write
  input wire        hready,       // bus ready
  input wire [31:0] hrdata,       // read data
  input wire        hreadyout,    // slave ready
  input wire        hresp,        // response
  input wire [15:0] raw_temp,     // measured
  input wire [15:0] cal_temp,     // calibrated
  input wire        refresh_done  // loaded
);
  logic [31:0] cnt_q;
  logic        wr1_q;
  logic        wr2_q;
  wire         acc = hsel && hready && htrans[1];
  wire  [15:0] offs = cal_temp - raw_temp;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // edge counter since reset and delayed write markers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 32'h0;
      wr1_q <= 1'b0;
      wr2_q <= 1'b0;
    end else begin
      if (cnt_q <= REFRESH_CYCLES) cnt_q <= cnt_q + 32'h1;
      wr1_q <= acc && hwrite;
      wr2_q <= wr1_q;
    end
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (
    acc && !hwrite |-> ##1 !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  a_load_count: assert property (
    refresh_done == (cnt_q >= REFRESH_CYCLES))
    else $error("load at wrong edge");
  a_done_sticky: assert property (
    $past(refresh_done) |-> refresh_done)
    else $error("loaded flag dropped");
  a_cal_offset: assert property (
    !$rose(refresh_done) && !wr1_q && !wr2_q |-> $stable(offs))
    else $error("calibration offset moved");
  a_wo_reads_zero: assert property (
    acc && !hwrite && haddr[9:2] inside {`IDX_PASS0, `IDX_PASS1,
      `IDX_PASS2, `IDX_PASS3, `IDX_KEY, `IDX_UNLOCK}
    |-> ##2 hrdata == 32'h0)
    else $error("write only register read nonzero");
  a_hrdata_hold: assert property (
    hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
endmodule
bind temp_ref_and_passcode_mirror mirror_sva #(
  .REFRESH_CYCLES(REFRESH_CYCLES)
) u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .raw_temp(raw_temp),
  .cal_temp(cal_temp), .refresh_done(refresh_done));

// >>> sim/tb.sv
// Purpose: self-checking bench for the mirror block
// Assumes: one wait state on reads, shortened refresh delay
// Notes:   reads note expectations in a queue, a monitor compares
`timescale 1ns/1ns
`include "mirror_consts.vh"
module tb;
  localparam [`REFR_CNT_W-1:0] RC = 40; // shortened delay
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] nv_temp_ref = 16'h0;
  logic [31:0] nv_passcode = 32'h0;
  logic [7:0]  nv_enable_key = 8'h0;
  logic [15:0] raw_temp = 16'h0;
  logic        seconds_write = 1'b0;
  logic        external_event_input = 1'b0;
  logic        xtal_clk_in = 1'b0;
  logic        comp_pulse = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire  [15:0] cal_temp;
  wire         clkout;
  wire         refresh_done;
  logic [31:0] exp_q [$];
  int          fail_count = 0;
  int          checks_done = 0;
  logic        rd_dp = 1'b0;
  logic [31:0] seed_v;
  logic [31:0] p2;
  logic [15:0] tr;
  logic [12:0] code;
  int          rises;
  always #5 hclk = ~hclk;
  temp_ref_and_passcode_mirror #(.REFRESH_CYCLES(RC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .nv_temp_ref(nv_temp_ref), .nv_passcode(nv_passcode),
    .nv_enable_key(nv_enable_key), .raw_temp(raw_temp),
    .seconds_write(seconds_write),
    .external_event_input(external_event_input),
    .xtal_clk_in(xtal_clk_in), .comp_pulse(comp_pulse),
    .cal_temp(cal_temp), .clkout(clkout), .refresh_done(refresh_done));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // wait for hready; only the watchdog ends a wait that never ends
  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, i, 2'b00};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, i, 32'h0);
  endtask
  task automatic do_reset(input logic [7:0] key);
    @(posedge hclk);
    hresetn <= 1'b0;
    nv_enable_key <= key;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic wait_done;
    for (int n = 0; n < 100 && refresh_done !== 1'b1; n++) @(posedge hclk);
  endtask
  // read data monitor: compare at the end of each read data phase
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front());
    if (hreadyout === 1'b1) rd_dp = hsel && htrans[1] && !hwrite;
  end
  initial begin
    #100000;
    fail_count++;
    complete_run;
  end
  initial begin
    seed_v = $urandom(32'he1e5);
    nv_temp_ref <= $urandom;
    nv_passcode <= $urandom | 32'h1;
    raw_temp <= $urandom;
    do_reset(8'hfe);
    rd(`IDX_STATUS, 32'h4);
    rd(`IDX_TEMP_REF_OFFSET_LO, 32'h0);
    wait_done;
    rd(`IDX_TEMP_REF_OFFSET_LO, {24'h0, nv_temp_ref[7:0]});
    rd(`IDX_TEMP_REF_OFFSET_HI, {24'h0, nv_temp_ref[15:8]});
    rd(`IDX_STATUS, 32'h1);
    rd(`IDX_NV_PASS, 32'h0);
    for (int i = 0; i < 4; i++) rd(8'(`IDX_PASS0 + i), 32'h0);
    rd(8'h20, 32'h0);
    rd(`IDX_CAL_TEMP, {16'h0, raw_temp + nv_temp_ref});
    tr = $urandom | 16'h8000;
    bus(1'b1, `IDX_TEMP_REF_OFFSET_LO, {24'h0, tr[7:0]});
    bus(1'b1, `IDX_TEMP_REF_OFFSET_HI, {24'h0, tr[15:8]});
    rd(`IDX_CAL_TEMP, {16'h0, raw_temp + tr});
    p2 = $urandom;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'(`IDX_PASS0 + i), {24'h0, p2[8*i +: 8]});
    end
    bus(1'b1, `IDX_UNLOCK, nv_passcode);
    rd(`IDX_STATUS, 32'h1);
    bus(1'b1, `IDX_UNLOCK, p2);
    rd(`IDX_NV_PASS, nv_passcode);
    // high_freq_output_mode: rising edges counted while seconds and events pulse
    for (int k = 0; k < 2; k++) begin
      code = k ? 13'h0fff : 13'h03ff;
      bus(1'b1, `IDX_CTRL, {14'h0, 2'b11, 3'h0, code});
      rises = 0;
      repeat (256) begin
        @(posedge hclk);
        if (clkout === 1'b1 && xtal_clk_in === 1'b0) rises++;
        xtal_clk_in <= clkout;
        seconds_write <= $urandom;
        external_event_input <= $urandom;
        comp_pulse <= 1'b1;
      end
      chk(rises, (code + 1) >> 6);
    end
    bus(1'b1, `IDX_CTRL, 32'h0);
    for (int j = 0; j < 4; j++) begin
      @(posedge hclk);
      xtal_clk_in <= j[0];
      comp_pulse <= j[1];
      #1 chk(clkout, j == 1);
    end
    do_reset(`KEY_ENABLED);
    wait_done;
    rd(`IDX_STATUS, 32'h3);
    bus(1'b1, `IDX_TEMP_REF_OFFSET_LO, {24'h0, ~nv_temp_ref[7:0]});
    rd(`IDX_TEMP_REF_OFFSET_LO, {24'h0, nv_temp_ref[7:0]});
    bus(1'b1, `IDX_PASS0, {24'h0, ~nv_passcode[7:0]});
    bus(1'b1, `IDX_UNLOCK, nv_passcode);
    rd(`IDX_STATUS, 32'h5);
    bus(1'b1, `IDX_TEMP_REF_OFFSET_LO, {24'h0, ~nv_temp_ref[7:0]});
    rd(`IDX_TEMP_REF_OFFSET_LO, {24'h0, ~nv_temp_ref[7:0]});
    repeat (4) @(posedge hclk);
    complete_run;
  end
endmodule
